// [shared/fault_mgr_cfg.svh]
// constants for the motor driver fault manager: widths, channel positions, policy codes, timing counts
// assumes the 200 MHz internal clock; included by the package and the design files
`ifndef FAULT_MGR_CFG_SVH
`define FAULT_MGR_CFG_SVH

`define CLK_MHZ             200
// deglitch times in nanoseconds, counts rounded up to whole cycles
`define SUPPLY_DG_NS        10000
`define GATE_DG_NS          5000
`define DS_DG_NS            1000
`define DG_CYC(ns)          (((ns) * `CLK_MHZ + 999) / 1000)
`define SUPPLY_DG_CYC       `DG_CYC(`SUPPLY_DG_NS)
`define GATE_DG_CYC         `DG_CYC(`GATE_DG_NS)
`define DS_DG_CYC           `DG_CYC(`DS_DG_NS)
`define DG_W                12
`define NUM_FLT             7
// filter channel positions
`define F_MSUP              0
`define F_LPOR              1
`define F_GSUP              2
`define F_BST               3
`define F_DS                4
`define F_SHUNT             5
`define F_OT                6
// limit policy codes
`define POL_NEXT_FLAG       4'h0
`define POL_NEXT_QUIET      4'h1
`define POL_THR_FLAG        4'h2
`define POL_THR_QUIET       4'h3
`define POL_CNT_FLAG        4'h4
`define POL_CNT_QUIET       4'h5
`define POL_REPORT          4'h6
`define LIMIT_W             8
`define RETRY_W             4

`endif

// [shared/fault_mgr_pkg.sv]
// types for the motor driver fault manager
// assumes fault_mgr_cfg.svh is on the include path
package fault_mgr_pkg;
	`include "fault_mgr_cfg.svh"

	typedef enum logic [1:0] {LIM_IDLE, LIM_NEXT, LIM_THR, LIM_CNT} lim_state_t;

	// gate outputs, high side and low side per phase
	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} gate_t;

	// status returned to the host; the latched fault flags and the report-only limit flags are sticky
	typedef struct packed {
		logic motor_supply_undervolt;
		logic logic_supply_por;
		logic gate_supply_undervolt;
		logic bootstrap_undervolt;
		logic drain_source_overcurrent;
		logic shunt_overcurrent;
		logic overtemp_shutdown;
		logic cycle_limit;
		logic controller_fault;
	} status_t;
endpackage

// [hw/deglitch.sv]
// one deglitch filter: an event is declared after a continuous run of raw assertion
// assumes the raw input is already synchronous to mclk
`timescale 1ns/1ps
`include "fault_mgr_cfg.svh"
module deglitch (
	input  wire logic             mclk,    // internal clock
	input  wire logic             rst_n,   // synchronous reset, active low
	input  wire logic [`DG_W-1:0] len,     // deglitch length in cycles
	input  wire logic             raw,     // raw fault level
	output logic                  hit      // deglitched fault level
);
	logic [`DG_W-1:0] cnt_r, cnt_nxt;
	logic             hit_r, hit_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		hit_nxt = hit_r;
		if (!raw) begin
			cnt_nxt = '0;
			hit_nxt = 1'b0;
		end else if (cnt_r >= len - `DG_W'(1)) begin
			hit_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + `DG_W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_r <= '0;
			hit_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			hit_r <= hit_nxt;
		end
	end

	assign hit = hit_r;
endmodule

// [hw/motor_driver_fault_manager.sv]
// fault manager for a three-phase gate driver: filters fault levels, forces gate states,
// drives the fault indicator and keeps status flags.
// assumes raw fault and comparator levels come from analog blocks outside mclk's domain
// and that pwm_cycle_start and closed_loop come from logic on mclk.
`timescale 1ns/1ps
`include "fault_mgr_cfg.svh"
module motor_driver_fault_manager (
	input  wire logic                      mclk,                      // 200 MHz internal clock
	input  wire logic                      rst_n,                     // synchronous reset, active low
	input  wire logic                      motor_supply_undervolt,    // raw motor supply low level
	input  wire logic                      logic_supply_por,          // raw logic supply below reset level
	input  wire logic                      gate_supply_undervolt,     // raw gate supply low level
	input  wire logic [2:0]                bootstrap_undervolt,       // raw bootstrap low, one per phase
	input  wire logic [5:0]                drain_source_trip,         // raw drain-source compare, hi 2:0 lo 5:3
	input  wire logic                      shunt_trip,                // raw shunt above fixed threshold
	input  wire logic                      overtemp_trip,             // raw die temperature above trip
	input  wire logic                      limit_cmp,                 // raw current-sense above limit
	input  wire logic                      fault_clear_cmd,           // fault clear pulse
	input  wire logic                      drain_source_check_off,    // 1 disables drain-source check
	input  wire logic                      shunt_check_off,           // 1 disables shunt check
	input  wire logic [1:0]                drain_source_threshold_sel,// threshold select, passed out
	input  wire logic                      overtemp_self_recover,     // 1 automatic, 0 latched
	input  wire logic [3:0]                cycle_limit_policy,        // limit policy
	input  wire logic [`LIMIT_W-1:0]       cycle_current_limit,       // closed loop limit level
	input  wire logic [`LIMIT_W-1:0]       open_loop_limit_cfg,       // open loop limit level
	input  wire logic                      closed_loop,               // 1 in closed loop operation
	input  wire logic [`RETRY_W-1:0]       limit_retry_cycles,        // retry count for policy 010x
	input  wire logic                      pwm_cycle_start,           // one-cycle pulse at PWM period start
	input  wire logic                      full_duty,                 // commanded duty is 100%
	input  wire fault_mgr_pkg::gate_t      gate_cmd,                  // gate commands from commutation
	output fault_mgr_pkg::gate_t           gate_out,                  // gate outputs to the bridge
	output logic                           fault_indicator_n,         // fault pin, active low
	output logic                           charge_pump_en,            // charge pump enable
	output logic                           logic_en,                  // internal logic enable
	output logic [`LIMIT_W-1:0]            limit_level,               // selected limit to comparator dac
	output logic [1:0]                     ds_threshold,              // threshold select to monitors
	output fault_mgr_pkg::status_t         status                     // fault status flags
);
	////////////////////////////////////////////////////////////////////////////////
	// three-flop synchronisers for the analog levels
	localparam int NRAW = 15;
	logic [NRAW-1:0] raw_in;
	logic [NRAW-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;

	assign raw_in = {limit_cmp, overtemp_trip, shunt_trip, drain_source_trip,
		bootstrap_undervolt, gate_supply_undervolt, logic_supply_por, motor_supply_undervolt};

	// a change is taken only once the second and third flops agree
	always_comb begin
		for (int i = 0; i < NRAW; i++) begin
			lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			lvl_r <= '0;
		end else begin
			s1_r  <= raw_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// deglitch filters, one per fault
	logic [`NUM_FLT-1:0] flt_raw;
	logic [`NUM_FLT-1:0] flt_hit;
	logic [`DG_W-1:0]    dg_len [`NUM_FLT];
	logic                lim_lvl;

	assign flt_raw[`F_MSUP]  = lvl_r[0];
	assign flt_raw[`F_LPOR]  = lvl_r[1];
	assign flt_raw[`F_GSUP]  = lvl_r[2];
	assign flt_raw[`F_BST]   = |lvl_r[5:3];
	assign flt_raw[`F_DS]    = |lvl_r[11:6] & ~drain_source_check_off;
	assign flt_raw[`F_SHUNT] = lvl_r[12] & ~shunt_check_off;
	assign flt_raw[`F_OT]    = lvl_r[13];
	assign lim_lvl           = lvl_r[14];

	assign dg_len[`F_MSUP]  = `DG_W'(`SUPPLY_DG_CYC);
	assign dg_len[`F_LPOR]  = `DG_W'(`SUPPLY_DG_CYC);
	assign dg_len[`F_GSUP]  = `DG_W'(`GATE_DG_CYC);
	assign dg_len[`F_BST]   = `DG_W'(`GATE_DG_CYC);
	assign dg_len[`F_DS]    = `DG_W'(`DS_DG_CYC);
	assign dg_len[`F_SHUNT] = `DG_W'(`DS_DG_CYC);
	assign dg_len[`F_OT]    = `DG_W'(1);

	genvar g;
	generate
		for (g = 0; g < `NUM_FLT; g++) begin : g_dg
			deglitch u_dg (
				.mclk  (mclk),
				.rst_n (rst_n),
				.len   (dg_len[g]),
				.raw   (flt_raw[g]),
				.hit   (flt_hit[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// latched fault flags; the set wins over a clear in the same cycle
	logic [`NUM_FLT-1:0] latch_r, latch_nxt;
	logic [`NUM_FLT-1:0] latchable;

	always_comb begin
		latchable = '0;
		latchable[`F_GSUP]  = 1'b1;
		latchable[`F_BST]   = 1'b1;
		latchable[`F_DS]    = 1'b1;
		latchable[`F_SHUNT] = 1'b1;
		latchable[`F_OT]    = ~overtemp_self_recover;
		for (int i = 0; i < `NUM_FLT; i++) begin
			if (flt_hit[i])
				latch_nxt[i] = 1'b1;
			else if (!latchable[i] || fault_clear_cmd)
				latch_nxt[i] = 1'b0;
			else
				latch_nxt[i] = latch_r[i];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			latch_r <= '0;
		else
			latch_r <= latch_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// cycle-by-cycle limit policy
	fault_mgr_pkg::lim_state_t lim_r, lim_nxt;
	logic [`RETRY_W:0]         rcnt_r, rcnt_nxt;
	logic                      ctl_flag_r, ctl_flag_nxt;
	logic                      lim_flag_r, lim_flag_nxt;
	logic                      rep_r, rep_nxt;
	logic                      pulse_r, pulse_nxt;
	logic                      quiet;

	assign quiet = cycle_limit_policy[0];

	always_comb begin
		lim_nxt      = lim_r;
		rcnt_nxt     = rcnt_r;
		ctl_flag_nxt = ctl_flag_r;
		lim_flag_nxt = lim_flag_r;
		rep_nxt      = rep_r;
		pulse_nxt    = pulse_r;
		case (lim_r)
			fault_mgr_pkg::LIM_IDLE: begin
				if (lim_lvl) begin
					case (cycle_limit_policy)
						`POL_NEXT_FLAG, `POL_NEXT_QUIET: begin
							lim_nxt      = fault_mgr_pkg::LIM_NEXT;
							lim_flag_nxt = 1'b1;
							ctl_flag_nxt = ~quiet;
						end
						`POL_THR_FLAG, `POL_THR_QUIET: begin
							lim_nxt      = fault_mgr_pkg::LIM_THR;
							lim_flag_nxt = 1'b1;
							ctl_flag_nxt = ~quiet;
						end
						`POL_CNT_FLAG, `POL_CNT_QUIET: begin
							lim_nxt      = fault_mgr_pkg::LIM_CNT;
							rcnt_nxt     = {1'b0, limit_retry_cycles} + (`RETRY_W+1)'(1);
							lim_flag_nxt = 1'b1;
							ctl_flag_nxt = ~quiet;
						end
						`POL_REPORT: begin
							rep_nxt = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end
			fault_mgr_pkg::LIM_NEXT: begin
				if (pwm_cycle_start) begin
					lim_nxt      = fault_mgr_pkg::LIM_IDLE;
					lim_flag_nxt = 1'b0;
					ctl_flag_nxt = 1'b0;
				end
			end
			fault_mgr_pkg::LIM_THR: begin
				if (!lim_lvl) begin
					lim_nxt      = fault_mgr_pkg::LIM_IDLE;
					lim_flag_nxt = 1'b0;
					ctl_flag_nxt = 1'b0;
				end
			end
			fault_mgr_pkg::LIM_CNT: begin
				if (pwm_cycle_start) begin
					if (rcnt_r == (`RETRY_W+1)'(1)) begin
						lim_nxt      = fault_mgr_pkg::LIM_IDLE;
						lim_flag_nxt = 1'b0;
						ctl_flag_nxt = 1'b0;
					end
					rcnt_nxt = rcnt_r - (`RETRY_W+1)'(1);
				end
			end
			default: lim_nxt = fault_mgr_pkg::LIM_IDLE;
		endcase
		// report-only flags hold until the level ends and a clear arrives
		if (rep_r && !lim_lvl && fault_clear_cmd && !(lim_r == fault_mgr_pkg::LIM_IDLE
			&& lim_lvl && cycle_limit_policy == `POL_REPORT))
			rep_nxt = 1'b0;
		// at full duty with the limit level high in policy 0110, 0111 or 1xxx the high side drops for one clock at each PWM start, not for good
		pulse_nxt = pwm_cycle_start && full_duty && lim_lvl && (cycle_limit_policy == `POL_REPORT
			|| cycle_limit_policy == 4'h7 || cycle_limit_policy[3]);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lim_r      <= fault_mgr_pkg::LIM_IDLE;
			rcnt_r     <= '0;
			ctl_flag_r <= 1'b0;
			lim_flag_r <= 1'b0;
			rep_r      <= 1'b0;
			pulse_r    <= 1'b0;
		end else begin
			lim_r      <= lim_nxt;
			rcnt_r     <= rcnt_nxt;
			ctl_flag_r <= ctl_flag_nxt;
			lim_flag_r <= lim_flag_nxt;
			rep_r      <= rep_nxt;
			pulse_r    <= pulse_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output stage: every output is registered
	fault_mgr_pkg::gate_t   gate_r, gate_nxt;
	fault_mgr_pkg::status_t stat_r, stat_nxt;
	logic                   fin_n_r, fin_n_nxt;
	logic                   cp_r, cp_nxt, le_r, le_nxt;
	logic [`LIMIT_W-1:0]    lvl_sel_r, lvl_sel_nxt;
	logic [1:0]             dsth_r;
	logic                   supply_off, gates_low, recirc;
	logic [`NUM_FLT-1:0]    active;

	assign active     = flt_hit | latch_r;
	assign supply_off = active[`F_MSUP] | active[`F_LPOR];
	assign gates_low  = |active;
	assign recirc     = (lim_r != fault_mgr_pkg::LIM_IDLE);

	always_comb begin
		gate_nxt = gate_cmd;
		if (gates_low) begin
			gate_nxt = '0;
		end else if (recirc) begin
			gate_nxt.hi = 3'h0;
		end else if (pulse_r) begin
			gate_nxt.hi = 3'h0;
		end
		fin_n_nxt   = ~(gates_low | ctl_flag_r | rep_r);
		cp_nxt      = ~supply_off;
		le_nxt      = ~supply_off;
		lvl_sel_nxt = closed_loop ? cycle_current_limit : open_loop_limit_cfg;
		stat_nxt = '{
			motor_supply_undervolt:   active[`F_MSUP],
			logic_supply_por:         active[`F_LPOR],
			gate_supply_undervolt:    active[`F_GSUP],
			bootstrap_undervolt:      active[`F_BST],
			drain_source_overcurrent: active[`F_DS],
			shunt_overcurrent:        active[`F_SHUNT],
			overtemp_shutdown:        active[`F_OT],
			cycle_limit:              lim_flag_r | rep_r,
			controller_fault:         ctl_flag_r | rep_r
		};
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gate_r    <= '0;
			stat_r    <= '0;
			fin_n_r   <= 1'b1;
			cp_r      <= 1'b0;
			le_r      <= 1'b0;
			lvl_sel_r <= '0;
			dsth_r    <= '0;
		end else begin
			gate_r    <= gate_nxt;
			stat_r    <= stat_nxt;
			fin_n_r   <= fin_n_nxt;
			cp_r      <= cp_nxt;
			le_r      <= le_nxt;
			lvl_sel_r <= lvl_sel_nxt;
			dsth_r    <= drain_source_threshold_sel;
		end
	end

	assign gate_out          = gate_r;
	assign fault_indicator_n = fin_n_r;
	assign charge_pump_en    = cp_r;
	assign logic_en          = le_r;
	assign limit_level       = lvl_sel_r;
	assign ds_threshold      = dsth_r;
	assign status            = stat_r;
endmodule

// [verification/pwm_host_model.sv]
// host side model: PWM period starts and a rotating commutation pattern
// assumes it shares mclk with the fault manager and drives off the falling edge
`timescale 1ns/1ps
module pwm_host_model #(
	parameter int PER = 64                // PWM period in clock cycles
) (
	input  wire logic            mclk,     // clock
	input  wire logic            rst_n,    // reset
	output fault_mgr_pkg::gate_t gate_cmd, // gate commands
	output logic                 pwm_start // period start pulse
);
	int         cnt = 0;
	logic [1:0] ph = 2'h0;
	logic       pls = 1'b0;
	// one high side and the next phase's low side, never both of one phase
	assign gate_cmd = {3'h1 << ph, (ph == 2'h2) ? 3'h1 : 3'h2 << ph};
	assign pwm_start = pls;
	always @(negedge mclk) begin
		cnt <= (!rst_n || cnt == PER - 1) ? 0 : cnt + 1;
		pls <= rst_n && cnt == PER - 1;
		if (rst_n && cnt == PER - 1) begin
			ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		end
	end
endmodule

// [verification/fault_mgr_asserts.sv]
// assertions on the fault manager ports: fault actions, latching, limit policy
// assumes mclk alone and rst_n synchronous, active low
`timescale 1ns/1ps
`include "fault_mgr_cfg.svh"
module fault_mgr_asserts (
	input wire logic                   mclk,                   // clock
	input wire logic                   rst_n,                  // reset
	input wire logic                   motor_supply_undervolt, // raw
	input wire logic                   logic_supply_por,       // raw
	input wire logic                   gate_supply_undervolt,  // raw
	input wire logic [5:0]             drain_source_trip,      // raw
	input wire logic                   drain_source_check_off, // cfg
	input wire logic                   overtemp_self_recover,  // cfg
	input wire logic                   fault_clear_cmd,        // clear
	input wire logic                   closed_loop,            // cfg
	input wire logic [`LIMIT_W-1:0]    cycle_current_limit,    // cfg
	input wire logic [`LIMIT_W-1:0]    open_loop_limit_cfg,    // cfg
	input wire logic [3:0]             cycle_limit_policy,     // cfg
	input wire fault_mgr_pkg::gate_t   gate_out,               // out
	input wire logic                   fault_indicator_n,      // out
	input wire logic                   charge_pump_en,         // out
	input wire logic                   logic_en,               // out
	input wire logic [`LIMIT_W-1:0]    limit_level,            // out
	input wire fault_mgr_pkg::status_t status                  // out
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	logic [11:0] c_ms, c_lp, c_gs, c_ds, c_ok;
	logic [8:0]  stv;
	assign stv = status;
	// run lengths of raw levels; margins cover the synchroniser and output flop
	function automatic logic [11:0] run(input logic [11:0] c, input logic b);
		return b ? c + {11'h000, c != 12'hfff} : 12'h000;
	endfunction
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			{c_ms, c_lp, c_gs, c_ds, c_ok} <= '0;
		end else begin
			c_ms <= run(c_ms, motor_supply_undervolt);
			c_lp <= run(c_lp, logic_supply_por);
			c_gs <= run(c_gs, gate_supply_undervolt);
			c_ds <= run(c_ds, |drain_source_trip && !drain_source_check_off);
			c_ok <= run(c_ok, !motor_supply_undervolt && !logic_supply_por);
		end
	end
	supply_off_a: assert property (c_ms > 12'h7dc |-> !fault_indicator_n && !charge_pump_en && !logic_en)
		else $error("motor supply fault not acted on");
	por_off_a: assert property (c_lp > 12'h7dc |-> !fault_indicator_n && !logic_en && gate_out == '0)
		else $error("logic supply reset not acted on");
	logic_back_a: assert property (c_ok > 12'h00c |-> logic_en && charge_pump_en)
		else $error("logic not resumed after supply return");
	gate_low_a: assert property (c_gs > 12'h3f4 && c_ok > 12'h00c |-> gate_out == '0 && !fault_indicator_n
		&& charge_pump_en)
		else $error("gate supply fault not acted on");
	ds_trip_a: assert property (c_ds > 12'h0d4 |-> gate_out == '0 && !fault_indicator_n)
		else $error("drain-source fault not acted on");
	latch_hold_a: assert property (!$past(fault_clear_cmd) |=> (stv[6:3] & $past(stv[6:3])) == $past(stv[6:3]))
		else $error("latched fault dropped without clear");
	ot_latch_a: assert property (status.overtemp_shutdown && !$past(overtemp_self_recover) && !$past(fault_clear_cmd)
		|=> status.overtemp_shutdown)
		else $error("latched overtemp dropped without clear");
	limit_sel_a: assert property (1'b1 |=> limit_level == ($past(closed_loop) ? $past(cycle_current_limit)
		: $past(open_loop_limit_cfg)))
		else $error("wrong limit level selected");
	recirc_hi_a: assert property (status.cycle_limit && $past(status.cycle_limit) && cycle_limit_policy < 4'h6
		|-> gate_out.hi == 3'h0)
		else $error("high side driven while limiting");
	quiet_pol_a: assert property ((cycle_limit_policy[0] || cycle_limit_policy[3]) && $stable(cycle_limit_policy)
		|-> !$rose(status.controller_fault))
		else $error("controller fault raised in quiet policy");
	off_none_a: assert property (cycle_limit_policy[3] || cycle_limit_policy == 4'h7 |-> !$rose(status.cycle_limit))
		else $error("limit flagged in disabled policy");
endmodule
bind motor_driver_fault_manager fault_mgr_asserts chk_u (.mclk, .rst_n, .motor_supply_undervolt, .logic_supply_por,
	.gate_supply_undervolt, .drain_source_trip, .drain_source_check_off, .overtemp_self_recover, .fault_clear_cmd,
	.closed_loop, .cycle_current_limit, .open_loop_limit_cfg, .cycle_limit_policy, .gate_out, .fault_indicator_n,
	.charge_pump_en, .logic_en, .limit_level, .status);

// [verification/motor_driver_fault_manager_tb.sv]
// self-checking bench for the fault manager: fault kinds, glitches, limit policies
// assumes the host model drives PWM starts and gate commands
`timescale 1ns/1ps
`include "fault_mgr_cfg.svh"
module motor_driver_fault_manager_tb;
	localparam int PER = 64;
	logic                   mclk = 1'b0;
	logic                   rst_n = 1'b0;
	logic [6:0]             raw_k = 7'h00;
	logic [1:0]             bsel = 2'h0;
	logic [2:0]             dsel = 3'h0;
	logic                   cmp = 1'b0;
	logic                   clr = 1'b0;
	logic                   ds_off = 1'b0;
	logic                   sh_off = 1'b0;
	logic                   ot_auto = 1'b0;
	logic                   cl = 1'b0;
	logic                   full = 1'b0;
	logic                   seen = 1'b0;
	logic [1:0]             ds_sel = 2'h0;
	logic [3:0]             pol = 4'h7;
	logic [3:0]             retry = 4'h0;
	logic [`LIMIT_W-1:0]    ccl = '0;
	logic [`LIMIT_W-1:0]    olc = '0;
	logic [`LIMIT_W-1:0]    lvl;
	logic                   pwm, ind_n, cp_en, lg_en;
	logic [1:0]             dsth;
	logic [8:0]             stv;
	logic [31:0]            r;
	logic [31:0]            seed = 32'h000109a2;
	fault_mgr_pkg::gate_t   gcmd, gout;
	fault_mgr_pkg::status_t st;
	int                     n_mismatch = 0;
	int                     tests_run = 0;
	int                     pre;
	assign stv = st;
	initial forever #2.5 mclk = ~mclk;
	pwm_host_model #(.PER(PER)) host_u (.mclk(mclk), .rst_n(rst_n), .gate_cmd(gcmd), .pwm_start(pwm));
	motor_driver_fault_manager dut_u (.mclk(mclk), .rst_n(rst_n), .motor_supply_undervolt(raw_k[0]),
		.logic_supply_por(raw_k[1]), .gate_supply_undervolt(raw_k[2]), .bootstrap_undervolt({2'h0, raw_k[3]} << bsel),
		.drain_source_trip({5'h00, raw_k[4]} << dsel), .shunt_trip(raw_k[5]), .overtemp_trip(raw_k[6]),
		.limit_cmp(cmp), .fault_clear_cmd(clr), .drain_source_check_off(ds_off), .shunt_check_off(sh_off),
		.drain_source_threshold_sel(ds_sel), .overtemp_self_recover(ot_auto), .cycle_limit_policy(pol),
		.cycle_current_limit(ccl), .open_loop_limit_cfg(olc), .closed_loop(cl), .limit_retry_cycles(retry),
		.pwm_cycle_start(pwm), .full_duty(full), .gate_cmd(gcmd), .gate_out(gout), .fault_indicator_n(ind_n),
		.charge_pump_en(cp_en), .logic_en(lg_en), .limit_level(lvl), .ds_threshold(dsth), .status(st));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic complete_run();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// a wait that runs out ends the run rather than hanging
	task automatic wait_ind(input logic v, input int lim);
		for (int i = 0; i < lim && ind_n !== v; i++) @(negedge mclk);
		if (ind_n !== v) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	// the start pulse changes on the falling edge, so it is looked at on the rising one
	task automatic wait_pwm();
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 2 * PER && !hit; i++) begin
			@(posedge mclk);
			hit = (pwm === 1'b1);
		end
		if (!hit) begin
			n_mismatch++;
			complete_run();
		end
		@(negedge mclk);
	endtask
	task automatic pulse_clr();
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(10);
		rst_n = 1'b1;
		repeat (8) begin
			r = rnd();
			{ccl, olc, ds_sel, cl} = r[18:0];
			cyc(3);
			chk(lvl, cl ? ccl : olc);
			chk(dsth, ds_sel);
		end
		for (int k = 0; k < 2; k++) begin
			raw_k[k] = 1'b1;
			cyc(1000);
			chk(ind_n, 1'b1);
			wait_ind(1'b0, 1200);
			chk({lg_en, cp_en, gout}, 8'h00);
			chk(stv[8 - k], 1'b1);
			raw_k[k] = 1'b0;
			wait_ind(1'b1, 40);
			cyc(2);
			chk({lg_en, cp_en}, 2'h3);
		end
		// two short runs must not add up to one event
		repeat (2) begin
			raw_k[4] = 1'b1;
			cyc(150);
			raw_k[4] = 1'b0;
			cyc(5);
		end
		chk(ind_n, 1'b1);
		for (int k = 2; k < 7; k++) begin
			r = rnd();
			bsel = (r[1:0] == 2'h3) ? 2'h0 : r[1:0];
			dsel = (r[4:2] > 3'h5) ? 3'h5 : r[4:2];
			pre = k < 4 ? 900 : (k < 6 ? 150 : 0);
			raw_k[k] = 1'b1;
			cyc(pre);
			if (pre > 0) chk(ind_n, 1'b1);
			wait_ind(1'b0, k < 6 ? 300 : 20);
			cyc(2);
			chk({cp_en, gout}, 7'h40);
			chk(stv[8 - k], 1'b1);
			pulse_clr();
			cyc(3);
			chk(ind_n, 1'b0);
			raw_k[k] = 1'b0;
			cyc(20);
			chk(ind_n, 1'b0);
			pulse_clr();
			wait_ind(1'b1, 20);
		end
		{ds_off, sh_off} = 2'h3;
		raw_k[5:4] = 2'h3;
		cyc(400);
		chk(ind_n, 1'b1);
		raw_k[5:4] = 2'h0;
		cyc(5);
		{ds_off, sh_off, ot_auto} = 3'h1;
		raw_k[6] = 1'b1;
		wait_ind(1'b0, 20);
		raw_k[6] = 1'b0;
		wait_ind(1'b1, 20);
		ot_auto = 1'b0;
		for (int p = 0; p < 16; p++) begin
			r = rnd();
			retry = {2'h0, r[1:0]};
			pol = p[3:0];
			wait_pwm();
			cmp = 1'b1;
			cyc(15);
			chk({stv[1:0], ind_n}, {p < 7, p < 7 && !p[0], !(p < 7 && !p[0])});
			chk(gout.hi, p < 6 ? 3'h0 : gcmd.hi);
			cmp = 1'b0;
			cyc(15);
			chk(stv[1], p < 2 || (p > 3 && p < 7));
			for (int j = 1; j <= retry + 2; j++) begin
				wait_pwm();
				cyc(4);
				if (j != retry + 1) chk({stv[1], ind_n}, {p == 6 || (p > 3 && p < 6 && j <= retry),
					!(p == 6 || (p == 4 && j <= retry))});
			end
			pulse_clr();
			cyc(4);
			chk({stv[1:0], ind_n}, 3'h1);
		end
		{pol, full, cmp} = 6'h1f;
		repeat (2 * PER) begin
			@(negedge mclk);
			seen = seen | (gout.hi === 3'h0);
		end
		chk(seen, 1'b1);
		{full, cmp} = 2'h0;
		cyc(10);
		complete_run();
	end
endmodule
